// [hw/cgr_pkg.sv]
package cgr_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0]  GAIN_HIGH_IDX    = 6'h2A;
   localparam logic [5:0]  GAIN_LOW_IDX     = 6'h2B;
   localparam logic [5:0]  CH7_CHANNEL_CONFIG_IDX      = 6'h2C;

   localparam logic [15:0] GAIN_HIGH_RESET  = 16'h8000;
   localparam logic [15:0] GAIN_LOW_RESET   = 16'h0000;
   localparam logic [15:0] CH7_CHANNEL_CONFIG_RESET    = 16'h0000;

   // writable bits of each register
   localparam logic [15:0] GAIN_HIGH_MASK   = 16'hFFFF;
   localparam logic [15:0] GAIN_LOW_MASK    = 16'hFF00;
   localparam logic [15:0] CH7_CHANNEL_CONFIG_MASK     = 16'hFFC7;

   // field positions in the channel-7 config word
   localparam int          PHASE_HI_LSB     = 8;
   localparam int          PHASE_LO_LSB     = 6;
   localparam int          DC_DIS_BIT       = 2;
   localparam int          SEL_LSB          = 0;

   typedef enum logic [1:0] {
      CGR_SEL_PINS,
      CGR_SEL_SHORTED,
      CGR_SEL_TEST_POS,
      CGR_SEL_TEST_NEG
   } cgr_sel_t;

   // decoded channel settings handed to the converter datapath
   typedef struct packed {
      logic [23:0] gain_coeff;
      logic [9:0]  phase_delay;
      logic        dc_block_bypass;
      cgr_sel_t    input_select;
   } cgr_chan_t;

endpackage : cgr_pkg

// [hw/cgr_apb_if.sv]
`timescale 1ns/10ps
// apb slave front end: zero wait states, one write or read pulse per access
module cgr_apb_slave (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   output logic             wr_stb,
   output logic             rd_stb,
   output logic [5:0]       reg_idx,
   output logic             misaligned
);
   // access completes in the first access-phase cycle, pready is tied high outside
   assign wr_stb     = psel & penable & pwrite;
   assign rd_stb     = psel & penable & ~pwrite;
   assign reg_idx    = paddr[7:2];
   assign misaligned = (paddr[1:0] != 2'b00) | (paddr[11:8] != 4'h0);
endmodule : cgr_apb_slave

// [hw/cgr_regs.sv]
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module cgr_regs (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic                     pready,
   output logic                     pslverr,
   output logic [31:0]              prdata,
   input  wire logic                global_dc_block_setting,
   output cgr_pkg::cgr_chan_t       chan_q,
   output logic                     ch7_dc_block_active
);
   import cgr_pkg::*;

   logic        wr_stb;
   logic        rd_stb;
   logic [5:0]  reg_idx;
   logic        misaligned;
   logic        hit;
   logic [15:0] ch6_gain_trim_high_q, ch6_gain_trim_high_d;
   logic [15:0] ch6_gain_trim_low_q,  ch6_gain_trim_low_d;
   logic [15:0] ch7_channel_config_q, ch7_channel_config_d;
   logic [31:0] prdata_d;
   logic        pslverr_d;
   logic [15:0] wdata;
   cgr_chan_t   chan_d;
   logic [15:0] lane_en;
   logic        wr_gain_high;
   logic        wr_gain_low;
   logic        wr_ch7_channel_config;
   logic        setup_phase;
   logic [15:0] rd_view;

   cgr_apb_slave i_cgr_apb_slave (
      .clk        (clk),
      .reset_n    (reset_n),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .wr_stb     (wr_stb),
      .rd_stb     (rd_stb),
      .reg_idx    (reg_idx),
      .misaligned (misaligned)
   );

   // merge new write data into the writable bits, keep the rest
   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [15:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   // byte-lane write enables from the two low strobes
   function automatic logic [15:0] lane_mask(input logic [1:0] strb);
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
   endfunction : lane_mask

   // word index to one of the three mapped registers
   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx == GAIN_HIGH_IDX) || (idx == GAIN_LOW_IDX) || (idx == CH7_CHANNEL_CONFIG_IDX);
   endfunction : is_mapped

   // stored words to datapath settings; shared by reset and run so they cannot drift
   function automatic cgr_chan_t decode_chan(input logic [15:0] high_v,
                                             input logic [15:0] low_v,
                                             input logic [15:0] cfg_v);
      cgr_chan_t c;
      c.gain_coeff      = {high_v, low_v[15:8]};
      c.phase_delay     = {cfg_v[PHASE_HI_LSB +: 8], cfg_v[PHASE_LO_LSB +: 2]};
      c.dc_block_bypass = cfg_v[DC_DIS_BIT];
      c.input_select    = cgr_sel_t'(cfg_v[SEL_LSB +: 2]);
      decode_chan       = c;
   endfunction : decode_chan

   // decoded reset words, so chan_q starts at unity gain like the registers
   localparam cgr_chan_t CHAN_RESET = decode_chan(GAIN_HIGH_RESET, GAIN_LOW_RESET,
                                                  CH7_CHANNEL_CONFIG_RESET);

   // no wait states: every access ends in its first access cycle
   assign pready = 1'b1;

   // byte strobes gate the two low lanes; upper lanes have no storage
   always_comb begin
      wdata[7:0]  = pstrb[0] ? pwdata[7:0]  : 8'h00;
      wdata[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
   end

   always_comb begin
      hit = !misaligned && is_mapped(reg_idx);
   end

   // byte lanes the master asked to write
   always_comb begin
      lane_en = lane_mask(pstrb[1:0]);
   end

   // one write strobe per register, only for a clean aligned hit
   always_comb begin
      wr_gain_high = wr_stb && hit && (reg_idx == GAIN_HIGH_IDX);
      wr_gain_low  = wr_stb && hit && (reg_idx == GAIN_LOW_IDX);
      wr_ch7_channel_config   = wr_stb && hit && (reg_idx == CH7_CHANNEL_CONFIG_IDX);
   end

   // upper gain trim: all sixteen bits are coefficient bits 23:8
   always_comb begin
      ch6_gain_trim_high_d = ch6_gain_trim_high_q;
      if (wr_gain_high) begin
         ch6_gain_trim_high_d = merge(ch6_gain_trim_high_q, wdata,
                                      GAIN_HIGH_MASK & lane_en);
      end
   end

   // upper gain trim storage, unity gain out of reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ch6_gain_trim_high_q <= GAIN_HIGH_RESET;
      end else begin
         ch6_gain_trim_high_q <= ch6_gain_trim_high_d;
      end
   end

   // lower gain trim: only the upper byte is stored, the lower byte is reserved
   always_comb begin
      ch6_gain_trim_low_d = ch6_gain_trim_low_q;
      if (wr_gain_low) begin
         ch6_gain_trim_low_d = merge(ch6_gain_trim_low_q, wdata,
                                     GAIN_LOW_MASK & lane_en);
      end
   end

   // lower gain trim storage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ch6_gain_trim_low_q <= GAIN_LOW_RESET;
      end else begin
         ch6_gain_trim_low_q <= ch6_gain_trim_low_d;
      end
   end

   // channel-7 config: phase, dc disable and select; bits 5:3 never stored
   always_comb begin
      ch7_channel_config_d = ch7_channel_config_q;
      if (wr_ch7_channel_config) begin
         ch7_channel_config_d = merge(ch7_channel_config_q, wdata,
                                      CH7_CHANNEL_CONFIG_MASK & lane_en);
      end
   end

   // channel-7 config storage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ch7_channel_config_q <= CH7_CHANNEL_CONFIG_RESET;
      end else begin
         ch7_channel_config_q <= ch7_channel_config_d;
      end
   end

   // word shown for the addressed register; reserved bits forced to zero
   always_comb begin
      rd_view = 16'h0000;
      case (reg_idx)
         GAIN_HIGH_IDX: rd_view = ch6_gain_trim_high_q;
         GAIN_LOW_IDX:  rd_view = ch6_gain_trim_low_q & GAIN_LOW_MASK;
         CH7_CHANNEL_CONFIG_IDX:   rd_view = ch7_channel_config_q & CH7_CHANNEL_CONFIG_MASK;
         default:       rd_view = 16'h0000;
      endcase
   end

   // setup cycle of any transfer
   always_comb begin
      setup_phase = psel && !penable;
   end

   // response is built in the setup cycle so it stands through the access cycle
   always_comb begin
      prdata_d  = prdata;
      pslverr_d = 1'b0;
      if (setup_phase) begin
         prdata_d = 32'h0000_0000;
         if (hit && !pwrite) begin
            prdata_d = {16'h0000, rd_view};
         end
         pslverr_d = !hit;
      end
   end

   // response flops; prdata holds until the next setup cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_d;
         pslverr <= pslverr_d;
      end
   end

   // decoded settings, from the same function as their reset value
   always_comb begin
      chan_d = decode_chan(ch6_gain_trim_high_q, ch6_gain_trim_low_q, ch7_channel_config_q);
   end

   // settings register, one cycle behind the stored words
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chan_q <= CHAN_RESET;
      end else begin
         chan_q <= chan_d;
      end
   end

   // dc block off when bypassed per channel; otherwise the global setting rules
   assign ch7_dc_block_active = !chan_q.dc_block_bypass && global_dc_block_setting;

endmodule : cgr_regs

// [verif/cgr_regs_props.sv]
`timescale 1ns/10ps
module cgr_regs_props (
   input wire logic               clk,
   input wire logic               reset_n,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic [31:0]        prdata,
   input wire logic               pslverr,
   input wire logic               global_dc_block_setting,
   input wire cgr_pkg::cgr_chan_t chan_q,
   input wire logic               ch7_dc_block_active
);
   import cgr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // write data two edges back, lined up with the one-cycle lag of chan_q
   logic [15:0] wd1_q;
   logic [15:0] wd2_q;
   always_ff @(posedge clk) begin
      wd1_q <= pwdata[15:0];
      wd2_q <= wd1_q;
   end
   // committing write and access-phase read
   wire wr = psel && penable && pwrite && pstrb[1:0] == 2'b11;
   wire rd = psel && penable && !pwrite;
   a_gain_high: assert property (wr && paddr == 12'h0A8 |-> ##2
      chan_q.gain_coeff[23:8] == wd2_q) else $error("gain high not applied");
   a_gain_low: assert property (wr && paddr == 12'h0AC |-> ##2
      chan_q.gain_coeff[7:0] == wd2_q[15:8]) else $error("gain low not applied");
   a_phase_map: assert property (wr && paddr == 12'h0B0 |-> ##2
      chan_q.phase_delay == wd2_q[15:6]) else $error("phase field misplaced");
   a_select_map: assert property (wr && paddr == 12'h0B0 |-> ##2
      {chan_q.dc_block_bypass, chan_q.input_select} == wd2_q[2:0]) else $error("select wrong");
   a_dc_active: assert property (ch7_dc_block_active ==
      (!chan_q.dc_block_bypass && global_dc_block_setting)) else $error("dc block wrong");
   a_low_pad: assert property (rd && paddr == 12'h0AC |->
      prdata[7:0] == 8'h00) else $error("gain low pad not zero");
   a_cfg_pad: assert property (rd && paddr == 12'h0B0 |->
      prdata[5:3] == 3'h0 && prdata[31:16] == 16'h0000) else $error("config pad not zero");
   a_reset_vals: assert property ($rose(reset_n) |->
      chan_q == {24'h800000, 13'h0000}) else $error("reset values wrong");
   a_err_map: assert property (psel && penable |->
      pslverr == !(paddr inside {12'h0A8, 12'h0AC, 12'h0B0})) else $error("error flag wrong");
endmodule : cgr_regs_props
bind cgr_regs cgr_regs_props i_props (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pslverr, .global_dc_block_setting, .chan_q,
   .ch7_dc_block_active);

// [verif/cgr_regs_tb.sv]
`timescale 1ns/10ps
module cgr_regs_tb;
   import cgr_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        global_dc_block_setting = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        ch7_dc_block_active;
   cgr_chan_t   chan_q;
   int          fail_count = 0;
   int          checked = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   cgr_regs i_cgr_regs (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .pready, .pslverr, .prdata, .global_dc_block_setting, .chan_q, .ch7_dc_block_active);
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // one transfer; pready, prdata and pslverr are taken at the rising edge that ends it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // reset words on the bus and the decoded settings
   task automatic t_reset_vals();
      check("coeff reset", {8'h00, chan_q.gain_coeff}, 32'h0080_0000);
      check("fields reset", 32'({chan_q.phase_delay, chan_q.dc_block_bypass,
         chan_q.input_select}), 32'h0000_0000);
      apb(1'b0, 12'h0A8, 32'h0);
      check("high reset", rd, 32'h0000_8000);
      apb(1'b0, 12'h0AC, 32'h0);
      check("low reset", rd, 32'h0000_0000);
      apb(1'b0, 12'h0B0, 32'h0);
      check("config reset", rd, 32'h0000_0000);
      $display("reset value test done");
   endtask : t_reset_vals
   // reset pulse in mid-run while the registers hold written values
   task automatic t_reset();
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_vals();
      $display("mid-run reset test done");
   endtask : t_reset
   // low gain half with all-ones, high half with 1234, a single-lane write, unmapped and misaligned words
   task automatic t_gain();
      apb(1'b1, 12'h0AC, 32'hFFFF_FFFF);
      apb(1'b0, 12'h0AC, 32'h0);
      check("low readback", rd, 32'h0000_FF00);
      apb(1'b1, 12'h0A8, 32'h0000_1234);
      apb(1'b1, 12'h0B4, 32'hFFFF_FFFF);
      apb(1'b0, 12'h0B4, 32'h0);
      check("unmapped error", {err, rd[30:0]}, 32'h8000_0000);
      apb(1'b0, 12'h0A9, 32'h0);
      check("misaligned error", {err, rd[30:0]}, 32'h8000_0000);
      apb(1'b0, 12'h0A8, 32'h0);
      check("high readback", rd, 32'h0000_1234);
      check("coeff", {8'h00, chan_q.gain_coeff}, 32'h0012_34FF);
      pstrb <= 4'h1;
      apb(1'b1, 12'h0A8, 32'h0000_ABCD);
      pstrb <= 4'hF;
      apb(1'b0, 12'h0A8, 32'h0);
      check("lane write", rd, 32'h0000_12CD);
      $display("gain test done");
   endtask : t_gain
   // every select code and both bypass values against the global setting
   task automatic t_cfg();
      for (int i = 0; i < 8; i++) begin
         global_dc_block_setting <= ~i[1];
         apb(1'b1, 12'h0B0, 32'hFFFF_A5B8 | i);
         apb(1'b0, 12'h0B0, 32'h0);
         check("config readback", rd, 32'h0000_A580 | i);
         check("fields", 32'({chan_q.phase_delay, chan_q.dc_block_bypass, chan_q.input_select,
            ch7_dc_block_active}), 32'({10'h296, i[2:0], ~i[2] & ~i[1]}));
      end
      $display("config test done");
   endtask : t_cfg
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_vals();
      t_gain();
      t_cfg();
      t_reset();
      summarize();
   end
endmodule : cgr_regs_tb
